// [rtl/icpmc_client.sv]
`timescale 1ns/1ns
`include "icpmc_consts.svh"
module icpmc_client (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Link clock from the host (the serial clock itself)
  input wire logic scl_clock,
  // Serial data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Power mode and bus busy outputs
  output logic analog_enable,
  output logic measure_enable,
  output logic [2:0] oversampling_ratio,
  output logic bus_busy
);
  // ****************************************
  // Start and stop detection on data edges
  // ****************************************
  // Start/stop are seen by the data line clocking flops; the serial clock
  // is only sampled as data there, so no edge of it is ever missed.
  logic start_tgl;
  logic stop_tgl;
  logic [1:0] start_seen;
  logic [1:0] stop_seen;

  always_ff @(negedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      start_tgl <= 1'b0;
    end else if (scl_clock) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      stop_tgl <= 1'b0;
    end else if (scl_clock) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // ****************************************
  // Link domain: bit engine on serial clock
  // ****************************************
  icpmc_pkg::icpmc_state_t state;
  icpmc_pkg::icpmc_state_t next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic rw;
  logic next_rw;
  logic first;
  logic next_first;
  logic [3:0] index;
  logic [3:0] next_index;
  logic wr_tgl;
  logic next_wr_tgl;
  icpmc_pkg::icpmc_wr_t wr_hold;
  icpmc_pkg::icpmc_wr_t next_wr_hold;
  logic [1:0] start_ack;
  logic start_pend;
  logic [7:0] rd_byte;
  logic [`ICPMC_NUM_REGS*8-1:0] rd_flat;

  // Start handled on next rising edge: toggle differs from last seen
  always_ff @(posedge scl_clock or negedge rst_b) begin
    if (!rst_b) begin
      start_ack <= 2'h0;
    end else begin
      start_ack <= {start_ack[0], start_tgl};
    end
  end
  assign start_pend = start_ack[0] != start_tgl;
  // Register data read directly; writes arrive long before next read byte
  assign rd_byte = rd_flat[index*8 +: 8];

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_rw = rw;
    next_first = first;
    next_index = index;
    next_wr_tgl = wr_tgl;
    next_wr_hold = wr_hold;
    if (start_pend) begin
      next_state = icpmc_pkg::ICPMC_ADDR;
      next_shreg = {7'h00, sda_in};
      next_bitcnt = 3'h1;
    end else begin
      case (state)
        icpmc_pkg::ICPMC_IDLE: begin
        end
        icpmc_pkg::ICPMC_ADDR: begin
          next_shreg = {shreg[6:0], sda_in};
          next_bitcnt = 3'(bitcnt + 3'h1);
          if (bitcnt == 3'h7) begin
            if (shreg[6:0] == `ICPMC_CLIENT_ADDR && shreg[6:0] != `ICPMC_GENERAL_CALL) begin
              next_state = icpmc_pkg::ICPMC_AACK;
              next_rw = sda_in;
              next_first = ~sda_in;
            end else begin
              next_state = icpmc_pkg::ICPMC_IDLE;
            end
          end
        end
        icpmc_pkg::ICPMC_AACK: begin
          // Most significant read bit goes out on the fall after this edge
          next_bitcnt = 3'h0;
          next_shreg = rd_byte;
          next_state = rw ? icpmc_pkg::ICPMC_SEND : icpmc_pkg::ICPMC_RECV;
        end
        icpmc_pkg::ICPMC_RECV: begin
          next_shreg = {shreg[6:0], sda_in};
          next_bitcnt = 3'(bitcnt + 3'h1);
          if (bitcnt == 3'h7) begin
            next_state = icpmc_pkg::ICPMC_DACK;
            if (first) begin
              next_index = shreg[2:0] == 3'h0 && sda_in == 1'b0 ? 4'h0 : {shreg[2:0], sda_in};
              next_first = 1'b0;
            end else begin
              next_wr_hold.index = index;
              next_wr_hold.data = {shreg[6:0], sda_in};
              next_wr_tgl = ~wr_tgl;
              next_index = 4'(index + 4'h1);
            end
          end
        end
        icpmc_pkg::ICPMC_DACK: begin
          next_bitcnt = 3'h0;
          next_state = icpmc_pkg::ICPMC_RECV;
          if (rw) begin
            // Host ack bit sampled here; a nack ends the read
            if (sda_in) begin
              next_state = icpmc_pkg::ICPMC_IDLE;
            end else begin
              next_index = 4'(index + 4'h1);
              next_shreg = {rd_flat[4'(index + 4'h1)*8 +: 8]};
              next_state = icpmc_pkg::ICPMC_SEND;
            end
          end
        end
        icpmc_pkg::ICPMC_SEND: begin
          next_shreg = {shreg[6:0], 1'b0};
          next_bitcnt = 3'(bitcnt + 3'h1);
          if (bitcnt == 3'h7) begin
            next_state = icpmc_pkg::ICPMC_DACK;
          end
        end
        default: begin
          next_state = icpmc_pkg::ICPMC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= icpmc_pkg::ICPMC_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      rw <= 1'b0;
      first <= 1'b0;
      index <= 4'h0;
      wr_tgl <= 1'b0;
      wr_hold <= '0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      rw <= next_rw;
      first <= next_first;
      index <= next_index;
      wr_tgl <= next_wr_tgl;
      wr_hold <= next_wr_hold;
    end
  end

  // ****************************************
  // Data drive on falling serial clock
  // ****************************************
  // Changing data only after the clock falls keeps hold time and means
  // the clock line is never touched, so no stretching is possible.
  logic drive_low;
  logic next_drive_low;

  always_comb begin
    next_drive_low = 1'b0;
    case (state)
      icpmc_pkg::ICPMC_AACK: next_drive_low = 1'b1;
      icpmc_pkg::ICPMC_DACK: next_drive_low = ~rw;
      icpmc_pkg::ICPMC_SEND: next_drive_low = ~shreg[7];
      default: next_drive_low = 1'b0;
    endcase
    if (start_pend) begin
      next_drive_low = 1'b0;
    end
  end

  always_ff @(negedge scl_clock or negedge rst_b) begin
    if (!rst_b) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= next_drive_low;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  // ****************************************
  // Core domain: crossings, registers, mode
  // ****************************************
  logic wr_tgl_s;
  logic start_s;
  logic stop_s;
  logic wr_seen;
  logic next_wr_seen;
  logic busy_start;
  logic busy_stop;
  logic next_bus_busy;
  icpmc_pkg::icpmc_mode_t mode;
  logic next_analog_enable;
  logic [2:0] next_osr;

  icpmc_sync u_wr_sync (.clock(clock), .rst_b(rst_b), .din(wr_tgl), .dout(wr_tgl_s));
  icpmc_sync u_st_sync (.clock(clock), .rst_b(rst_b), .din(start_tgl), .dout(start_s));
  icpmc_sync u_sp_sync (.clock(clock), .rst_b(rst_b), .din(stop_tgl), .dout(stop_s));

  icpmc_regs u_regs (
    .clock(clock),
    .rst_b(rst_b),
    .wr_valid(wr_tgl_s != wr_seen),
    .wr(wr_hold),
    .rd_flat(rd_flat),
    .mode(mode)
  );

  always_comb begin
    next_wr_seen = rst_b ? wr_tgl_s : 1'b0;
    next_analog_enable = rst_b ? mode.active : 1'b0;
    next_osr = rst_b ? mode.oversampling_ratio : `ICPMC_OSR_FAST;
    busy_start = start_s != start_seen[0];
    busy_stop = stop_s != stop_seen[0];
    next_bus_busy = bus_busy;
    if (busy_start) begin
      next_bus_busy = 1'b1;
    end else if (busy_stop) begin
      next_bus_busy = 1'b0;
    end
    if (!rst_b) begin
      next_bus_busy = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    wr_seen <= next_wr_seen;
    start_seen <= rst_b ? {start_seen[0], start_s} : 2'h0;
    stop_seen <= rst_b ? {stop_seen[0], stop_s} : 2'h0;
    bus_busy <= next_bus_busy;
    analog_enable <= next_analog_enable;
    measure_enable <= next_analog_enable;
    oversampling_ratio <= next_osr;
  end
endmodule : icpmc_client

// [rtl/icpmc_consts.svh]
`ifndef ICPMC_CONSTS_SVH
`define ICPMC_CONSTS_SVH
// Client address and derived 8-bit forms
`define ICPMC_CLIENT_ADDR 7'h60
`define ICPMC_ADDR_READ 8'hC1
`define ICPMC_ADDR_WRITE 8'hC0
`define ICPMC_GENERAL_CALL 7'h00
// Register file
`define ICPMC_NUM_REGS 16
`define ICPMC_CTRL1_INDEX 4'h0
`define ICPMC_ACTIVE_BIT 0
`define ICPMC_OSR_LSB 3
`define ICPMC_OSR_MSB 5
`define ICPMC_CTRL1_RESET 8'h00
`define ICPMC_STATUS_INDEX 4'h1
`define ICPMC_OSR_FAST 3'h0
`define ICPMC_OSR_FINE 3'h7
`endif

// [rtl/icpmc_pkg.sv]
package icpmc_pkg;
  // Link-side state of the serial client
  typedef enum logic [5:0] {
    ICPMC_IDLE = 6'h01,
    ICPMC_ADDR = 6'h02,
    ICPMC_AACK = 6'h04,
    ICPMC_RECV = 6'h08,
    ICPMC_SEND = 6'h10,
    ICPMC_DACK = 6'h20
  } icpmc_state_t;

  // One register write handed to the core domain
  typedef struct packed {
    logic [3:0] index;
    logic [7:0] data;
  } icpmc_wr_t;

  // Power mode view derived from the first control register
  typedef struct packed {
    logic active;
    logic [2:0] oversampling_ratio;
  } icpmc_mode_t;
endpackage : icpmc_pkg

// [rtl/icpmc_regs.sv]
`timescale 1ns/1ns
`include "icpmc_consts.svh"
// Register file in the core clock domain
module icpmc_regs (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Write port
  input wire logic wr_valid,
  input wire icpmc_pkg::icpmc_wr_t wr,
  // Read view
  output logic [`ICPMC_NUM_REGS*8-1:0] rd_flat,
  // Mode
  output icpmc_pkg::icpmc_mode_t mode
);
  logic [7:0] mem [0:`ICPMC_NUM_REGS-1];
  logic [7:0] next_mem [0:`ICPMC_NUM_REGS-1];
  icpmc_pkg::icpmc_mode_t next_mode;

  always_comb begin
    for (int i = 0; i < `ICPMC_NUM_REGS; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_valid && wr.index != `ICPMC_STATUS_INDEX) begin
      next_mem[wr.index] = wr.data;
    end
    // Status shows the live mode so software sees its own effect
    next_mem[`ICPMC_STATUS_INDEX] = {4'h0, mode};
    if (!rst_b) begin
      for (int i = 0; i < `ICPMC_NUM_REGS; i++) begin
        next_mem[i] = 8'h00;
      end
      next_mem[`ICPMC_CTRL1_INDEX] = `ICPMC_CTRL1_RESET;
    end
    next_mode.active = next_mem[`ICPMC_CTRL1_INDEX][`ICPMC_ACTIVE_BIT];
    next_mode.oversampling_ratio = next_mem[`ICPMC_CTRL1_INDEX][`ICPMC_OSR_MSB:`ICPMC_OSR_LSB];
  end

  always_ff @(posedge clock) begin
    mem <= next_mem;
    mode <= next_mode;
  end

  generate
    for (genvar g = 0; g < `ICPMC_NUM_REGS; g++) begin : g_flat
      assign rd_flat[g*8 +: 8] = mem[g];
    end
  endgenerate
endmodule : icpmc_regs

// [rtl/icpmc_sync.sv]
`timescale 1ns/1ns
// Two-flop level synchroniser
module icpmc_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb begin
    // Reset low to match the toggles, so no false edge follows reset
    next_stage1 = rst_b ? din : 1'b0;
    next_dout = rst_b ? stage1 : 1'b0;
  end

  always_ff @(posedge clock) begin
    stage1 <= next_stage1;
    dout <= next_dout;
  end
endmodule : icpmc_sync

// [testbench/icpmc_client_properties.sv]
`timescale 1ns/1ns
// ****
// Client port checks
// ****
module icpmc_client_props (
  // Clocks, reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl_clock,
  // Data pin
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Mode
  input wire logic analog_enable,
  input wire logic measure_enable,
  input wire logic [2:0] oversampling_ratio,
  input wire logic bus_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_start;
    $fell(sda_in) && scl_clock && $past(scl_clock);
  endsequence
  sequence s_stop;
    $rose(sda_in) && scl_clock && $past(scl_clock);
  endsequence
  a_start_sets_busy: assert property (s_start |-> ##[1:6] bus_busy)
    else $error("no busy");
  a_stop_clears_busy: assert property (s_stop |-> ##[1:6] !bus_busy)
    else $error("busy kept");
  a_drive_low_only: assert property (sda_oe |-> !sda_out)
    else $error("pin driven high");
  a_oe_steady_high: assert property (scl_clock && $past(scl_clock) |-> $stable(sda_oe))
    else $error("data moved in high phase");
  a_no_clock_stretch: assert property ($changed(sda_oe) |-> !scl_clock)
    else $error("drive outside low phase");
  a_drive_when_busy: assert property (sda_oe |-> bus_busy)
    else $error("drive while idle");
  a_measure_with_analog: assert property (measure_enable == analog_enable)
    else $error("measure mismatch");
  // Mode may only move while a frame is open
  a_mode_via_port: assert property ($changed({analog_enable, oversampling_ratio}) |-> bus_busy)
    else $error("mode moved while idle");
endmodule : icpmc_client_props

bind icpmc_client icpmc_client_props u_icpmc_client_props (.clock(clock), .rst_b(rst_b), .scl_clock(scl_clock),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .analog_enable(analog_enable),
  .measure_enable(measure_enable), .oversampling_ratio(oversampling_ratio), .bus_busy(bus_busy));

// [testbench/icpmc_client_tb.sv]
`timescale 1ns/1ns
// ****
// Client bench
// ****
module icpmc_client_tb;
  typedef struct packed {
    logic [7:0] data;
    logic [3:0] mode;
  } icpmc_row_t;
  // Written byte beside {analog, ratio}
  icpmc_row_t rows [4] = '{{8'h01, 4'h8}, {8'h39, 4'hF}, {8'h38, 4'h7}, {8'h29, 4'hD}};
  logic [7:0] bad [3] = '{8'hC2, 8'h00, 8'hC3};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic scl_clock;
  logic host_low;
  logic sda_out;
  logic sda_oe;
  logic analog_enable;
  logic measure_enable;
  logic [2:0] oversampling_ratio;
  logic bus_busy;
  logic ack;
  logic [7:0] rd;
  int miscompares = 0;
  int n_checks = 0;
  // Pull-up wins unless a party pulls low
  wire sda = !(host_low || (sda_oe === 1'b1 && sda_out !== 1'b1));
  always #10 clock = ~clock;
  icpmc_client u_icpmc_client (.clock(clock), .rst_b(rst_b), .scl_clock(scl_clock), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .analog_enable(analog_enable), .measure_enable(measure_enable),
    .oversampling_ratio(oversampling_ratio), .bus_busy(bus_busy));
  icpmc_host u_icpmc_host (.scl_clock(scl_clock), .host_low(host_low), .sda(sda));
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : chk
  task automatic send(input logic [7:0] d, input logic exp_ack);
    u_icpmc_host.wr_byte(d, ack);
    chk({7'h00, ack}, {7'h00, exp_ack}, "ack");
  endtask : send
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clock);
    u_icpmc_host.bus_start();
    send(8'hC0, 1'b1);
    send(idx, 1'b1);
    send(d, 1'b1);
    u_icpmc_host.bus_stop();
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clock);
    u_icpmc_host.bus_start();
    repeat (4) @(negedge clock);
    chk({7'h00, bus_busy}, 8'h01, "busy");
    send(8'hC0, 1'b1);
    send(idx, 1'b1);
    u_icpmc_host.bus_start();
    send(8'hC1, 1'b1);
    u_icpmc_host.rd_byte(1'b1, rd);
    u_icpmc_host.bus_stop();
    repeat (8) @(negedge clock);
    chk({7'h00, bus_busy}, 8'h00, "idle");
    chk(rd, exp, "read");
  endtask : rd_reg
  initial begin
    repeat (20) @(negedge clock);
    chk({3'h0, analog_enable, measure_enable, oversampling_ratio}, 8'h00, "reset");
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    chk({3'h0, analog_enable, measure_enable, oversampling_ratio}, 8'h00, "standby");
    foreach (rows[i]) begin
      wr_reg(8'h00, rows[i].data);
      repeat (8) @(negedge clock);
      chk({4'h0, analog_enable, oversampling_ratio}, {4'h0, rows[i].mode}, "mode");
      chk({7'h00, measure_enable}, {7'h00, rows[i].mode[3]}, "measure");
    end
    rd_reg(8'h00, 8'h29);
    foreach (bad[i]) begin
      @(negedge clock);
      u_icpmc_host.bus_start();
      send(bad[i], 1'b0);
      u_icpmc_host.bus_stop();
    end
    @(negedge clock);
    u_icpmc_host.bus_start();
    send(8'hC0, 1'b1);
    send(8'h0F, 1'b1);
    send(8'h11, 1'b1);
    #400; // Clock held low between bytes
    send(8'h00, 1'b1); // Index wraps to reg 0
    u_icpmc_host.bus_stop();
    repeat (8) @(negedge clock);
    chk({4'h0, analog_enable, oversampling_ratio}, 8'h00, "wrap");
    rd_reg(8'h0F, 8'h11); // Stored data served in standby
    end_sim();
  end
  // Run needs well under 100 us
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule : icpmc_client_tb

// [testbench/icpmc_host.sv]
`timescale 1ns/1ns
// ****
// Host end of the serial bus
// ****
module icpmc_host (
  // Serial lines
  output logic scl_clock,
  output logic host_low,
  input wire logic sda
);
  // Clock stands high outside frames
  initial begin
    scl_clock = 1'b1;
    host_low = 1'b0;
  end
  task automatic bus_start();
    #7 host_low = 1'b0;
    #20 scl_clock = 1'b1;
    #20 host_low = 1'b1;
    #20 scl_clock = 1'b0;
    #20;
  endtask : bus_start
  task automatic bus_stop();
    host_low = 1'b1;
    #20 scl_clock = 1'b1;
    #40 host_low = 1'b0;
    #40;
  endtask : bus_stop
  // Data only moves while the clock is low
  task automatic put_bit(input logic b, output logic s);
    host_low = !b;
    #20 scl_clock = 1'b1;
    #20 s = sda;
    #20 scl_clock = 1'b0;
    #20;
  endtask : put_bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s);
    end
    put_bit(1'b1, s);
    ack = !s;
  endtask : wr_byte
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(last, s);
  endtask : rd_byte
endmodule : icpmc_host
